// [pkg/smc_pkg.sv]
package smc_pkg;

   // register bus geometry
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] CMC_OFFSET = 12'h000;  // clock_mode_control
   localparam logic [APB_AW-1:0] CMC2_OFFSET = 12'h004; // clock_mode_control_second
   localparam logic [APB_AW-1:0] STAT_OFFSET = 12'h008; // mode status

   // clock_mode_control field positions
   localparam int CMC_HIGH_LOW_CLOCK_SELECT_BIT = 0;
   localparam int CMC_IDLE_BIT = 1;
   localparam int CMC_HTO_BIT = 2;
   localparam int CMC_LTO_BIT = 3;
   localparam int CMC_UNUSED_BIT = 4;
   localparam int CMC_LCKS_LSB = 5;
   localparam int CMC_LCKS_MSB = 7;

   // clock_mode_control_second field positions
   localparam int CMC2_KEEP_ON_BIT = 0;

   // status register field positions
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_MODE_MSB = 2;
   localparam int STAT_CPU_BIT = 3;
   localparam int STAT_FAST_BIT = 4;

   // reset values of the writable controls
   localparam logic HIGH_LOW_CLOCK_SELECT_RST = 1'b1;
   localparam logic IDLE_EN_RST = 1'b1;
   localparam logic [2:0] LCKS_RST = 3'h0;
   localparam logic KEEP_ON_RST = 1'b0;

   // low clock selector codes below this pick the slow rc clock
   localparam logic [2:0] LCKS_FIRST_DIV = 3'h2;
   // code + shift gives this constant: 010 -> /64 ... 111 -> /2
   localparam logic [3:0] LCKS_SHIFT_BASE = 4'h8;

   // oscillator ready delays after start, in pclk cycles
   localparam int HTO_WAKE_CYC = 16;
   localparam int LTO_WAKE_CYC = 2;
   localparam int HTO_CNT_W = 5;
   localparam int LTO_CNT_W = 2;

   // width of the fast clock divider counter (largest ratio 64)
   localparam int DIV_CNT_W = 6;
   localparam logic [DIV_CNT_W-1:0] DIV16_MASK = 6'h0f;
   localparam logic [DIV_CNT_W-1:0] DIV64_MASK = 6'h3f;

   // operating modes, gray coded along normal-slow-idle-sleep
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h0,
      MODE_SLOW = 3'h1,
      MODE_IDLE1 = 3'h3,
      MODE_IDLE0 = 3'h2,
      MODE_SLEEP1 = 3'h6,
      MODE_SLEEP0 = 3'h7
   } smc_mode_t;

endpackage

// [hdl/smc_clk_div.sv]
`timescale 1ns/1ps
module smc_clk_div
   import smc_pkg::*;
#(
   parameter int CNT_W = DIV_CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   input wire logic run,
   input wire logic [2:0] shift,
   output logic tick,
   output logic [CNT_W-1:0] count
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } smc_div_state_t;

   smc_div_state_t s_r;
   smc_div_state_t s_nxt;
   logic [CNT_W-1:0] mask;

   // ratio 2**shift: tick on the last count of each period
   always_comb begin
      mask = {CNT_W{1'b1}} >> (CNT_W - int'(shift));
      tick = run & ((s_r.cnt & mask) == mask);
      count = s_r.cnt;
   end

   // counter restarts on a source change so the first period is whole
   always_comb begin
      s_nxt = s_r;
      if (clr || !run) begin
         s_nxt.cnt = '0;
      end else begin
         s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// [hdl/smc_top.sv]
`timescale 1ns/1ps
// Function
// - select bit one picks fast clock
// - selector: 000/001 slow rc, else fast/64../2
// - slow rc selection stops fast oscillator
// - halt: sleep if idle off, else idle
// - idle with keep-on low stops system clock
// - idle with keep-on high keeps system clock
// - deepest sleep stops all clocks, watchdog
// - low voltage enable blocks deepest sleep
// - light sleep keeps slow peripheral clocks
// - accumulator clock only when halted, not deepest
// - substitute, slow clocks from slow rc
// - slow ready low in deep sleep, 2 cycles
// - fast ready follows oscillator, 16 cycles
// - unused bit four reads zero
// - normal mode runs cpu from fast clock
module smc_top
   import smc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic slow_rc_tick,
   input wire logic wdt_enable,
   input wire logic low_voltage_detect_enable,
   output logic cpu_clk_en,
   output logic sys_clk_en,
   output logic substitute_clock_en,
   output logic slow_peripheral_clock_en,
   output logic accumulator_clock_en,
   output logic fast_osc_on,
   output logic fast_div16_en,
   output logic fast_div64_en,
   output logic wdt_function_en,
   output logic cpu_halted
);

   typedef struct packed {
      smc_mode_t mode;
      logic high_low_clock_select;
      logic [2:0] low_clock_selector;
      logic idle_enable;
      logic system_clock_keep_on;
      logic act_fast;
      logic [2:0] act_sel;
      logic [HTO_CNT_W-1:0] hto_cnt;
      logic high_speed_ready_flag;
      logic [LTO_CNT_W-1:0] lto_cnt;
      logic low_speed_ready_flag;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic cpu_clk_en;
      logic sys_clk_en;
      logic sub_en;
      logic slow_per_en;
      logic acc_en;
      logic fast_on;
      logic div16_en;
      logic div64_en;
      logic wdt_en;
      logic halted;
   } smc_state_t;

   smc_state_t s_r;
   smc_state_t s_nxt;

   // true when the selector code picks the slow rc clock
   function automatic logic sel_is_slow_rc(input logic [2:0] sel);
      return sel < LCKS_FIRST_DIV;
   endfunction

   // divide ratio as a power of two: 010 -> 6 (/64) ... 111 -> 1 (/2)
   function automatic logic [2:0] sel_shift(input logic [2:0] sel);
      logic [3:0] sh;
      sh = LCKS_SHIFT_BASE - {1'b0, sel};
      return sh[2:0];
   endfunction

   // true for the two modes in which the cpu executes
   function automatic logic mode_running(input smc_mode_t m);
      return (m == MODE_NORMAL) || (m == MODE_SLOW);
   endfunction

   // register image of clock_mode_control
   function automatic logic [7:0] cmc_image(input smc_state_t st);
      logic [7:0] v;
      v = '0;
      v[CMC_HIGH_LOW_CLOCK_SELECT_BIT] = st.high_low_clock_select;
      v[CMC_IDLE_BIT] = st.idle_enable;
      v[CMC_HTO_BIT] = st.high_speed_ready_flag;
      v[CMC_LTO_BIT] = st.low_speed_ready_flag;
      v[CMC_UNUSED_BIT] = 1'b0;
      v[CMC_LCKS_MSB:CMC_LCKS_LSB] = st.low_clock_selector;
      return v;
   endfunction

   logic act_slow_rc;
   logic fast_run;
   logic slow_run;
   logic sel_change;
   logic src_ready;
   logic div_tick;
   logic div_clr;
   logic sys_tick;
   logic [2:0] div_shift;
   logic [DIV_CNT_W-1:0] div_count;
   logic wr_en;
   logic setup;

   // oscillator run conditions follow the mode and the active source
   always_comb begin
      act_slow_rc = !s_r.act_fast && sel_is_slow_rc(s_r.act_sel);
      fast_run = (mode_running(s_r.mode) || (s_r.mode == MODE_IDLE1))
                 && !act_slow_rc;
      slow_run = (s_r.mode != MODE_SLEEP0);
      sel_change = (s_r.high_low_clock_select != s_r.act_fast)
                   || (s_r.low_clock_selector != s_r.act_sel);
      src_ready = act_slow_rc ? s_r.low_speed_ready_flag
                              : s_r.high_speed_ready_flag;
      div_shift = s_r.act_fast ? 3'h0 : sel_shift(s_r.act_sel);
      sys_tick = act_slow_rc ? (slow_rc_tick && slow_run) : div_tick;
      div_clr = sel_change && (sys_tick || !src_ready);
   end

   // divider for the system clock taken from the fast oscillator
   smc_clk_div #(
      .CNT_W(DIV_CNT_W)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .clr(div_clr),
      .run(fast_run),
      .shift(div_shift),
      .tick(div_tick),
      .count(div_count)
   );

   // apb phases: answer comes in the first access cycle
   always_comb begin
      setup = psel && !penable;
      wr_en = psel && penable && s_r.pready && pwrite;
   end

   // next state of the whole block
   always_comb begin
      s_nxt = s_r;

      // bus slave: read data and error are prepared in the setup cycle
      s_nxt.pready = setup;
      if (setup) begin
         s_nxt.pslverr = 1'b0;
         s_nxt.prdata = '0;
         unique case (paddr)
            CMC_OFFSET: begin
               s_nxt.prdata[7:0] = cmc_image(s_r);
            end
            CMC2_OFFSET: begin
               s_nxt.prdata[CMC2_KEEP_ON_BIT] = s_r.system_clock_keep_on;
            end
            STAT_OFFSET: begin
               s_nxt.prdata[STAT_MODE_MSB:STAT_MODE_LSB] = s_r.mode;
               s_nxt.prdata[STAT_CPU_BIT] = !s_r.halted;
               s_nxt.prdata[STAT_FAST_BIT] = s_r.fast_on;
            end
            default: begin
               s_nxt.pslverr = 1'b1;
            end
         endcase
      end

      // register writes; ready flags are read only
      if (wr_en && (paddr == CMC_OFFSET)) begin
         s_nxt.high_low_clock_select = pwdata[CMC_HIGH_LOW_CLOCK_SELECT_BIT];
         s_nxt.idle_enable = pwdata[CMC_IDLE_BIT];
         s_nxt.low_clock_selector = pwdata[CMC_LCKS_MSB:CMC_LCKS_LSB];
      end
      if (wr_en && (paddr == CMC2_OFFSET)) begin
         s_nxt.system_clock_keep_on = pwdata[CMC2_KEEP_ON_BIT];
      end

      // source change only at a period boundary or while source is idle
      if (div_clr) begin
         s_nxt.act_fast = s_r.high_low_clock_select;
         s_nxt.act_sel = s_r.low_clock_selector;
      end

      // operating mode sequencing
      unique case (s_r.mode)
         MODE_NORMAL, MODE_SLOW: begin
            if (halt_req) begin
               if (s_r.idle_enable) begin
                  s_nxt.mode = s_r.system_clock_keep_on ? MODE_IDLE1
                                                        : MODE_IDLE0;
               end else if (wdt_enable || low_voltage_detect_enable) begin
                  s_nxt.mode = MODE_SLEEP1;
               end else begin
                  s_nxt.mode = MODE_SLEEP0;
               end
            end else begin
               s_nxt.mode = s_r.act_fast ? MODE_NORMAL : MODE_SLOW;
            end
         end
         MODE_IDLE0, MODE_IDLE1, MODE_SLEEP1, MODE_SLEEP0: begin
            if (wake_req) begin
               s_nxt.mode = s_r.act_fast ? MODE_NORMAL : MODE_SLOW;
            end
         end
         default: begin
            s_nxt.mode = MODE_NORMAL;
         end
      endcase

      // fast ready: cleared while stopped, set 16 cycles after start
      if (!fast_run) begin
         s_nxt.hto_cnt = '0;
         s_nxt.high_speed_ready_flag = 1'b0;
      end else if (!s_r.high_speed_ready_flag) begin
         s_nxt.hto_cnt = s_r.hto_cnt + HTO_CNT_W'(1);
         if (s_r.hto_cnt == HTO_CNT_W'(HTO_WAKE_CYC - 1)) begin
            s_nxt.high_speed_ready_flag = 1'b1;
         end
      end

      // slow ready: low in deepest sleep, set 2 cycles after wake
      if (!slow_run) begin
         s_nxt.lto_cnt = '0;
         s_nxt.low_speed_ready_flag = 1'b0;
      end else if (!s_r.low_speed_ready_flag) begin
         s_nxt.lto_cnt = s_r.lto_cnt + LTO_CNT_W'(1);
         if (s_r.lto_cnt == LTO_CNT_W'(LTO_WAKE_CYC - 1)) begin
            s_nxt.low_speed_ready_flag = 1'b1;
         end
      end

      // clock enables: one pulse per period of each clock; oscillator on, watchdog and halted are levels
      s_nxt.cpu_clk_en = mode_running(s_r.mode) && !halt_req
                         && sys_tick && src_ready;
      s_nxt.sys_clk_en = (mode_running(s_r.mode) || (s_r.mode == MODE_IDLE1))
                         && sys_tick && src_ready;
      s_nxt.sub_en = slow_run && slow_rc_tick;
      s_nxt.slow_per_en = slow_run && slow_rc_tick;
      s_nxt.acc_en = slow_rc_tick && ((s_r.mode == MODE_IDLE0)
                     || (s_r.mode == MODE_IDLE1)
                     || (s_r.mode == MODE_SLEEP1));
      s_nxt.fast_on = fast_run;
      s_nxt.div16_en = fast_run && s_r.high_speed_ready_flag
                       && ((div_count & DIV16_MASK) == DIV16_MASK);
      s_nxt.div64_en = fast_run && s_r.high_speed_ready_flag
                       && (div_count == DIV64_MASK);
      s_nxt.wdt_en = wdt_enable && (s_r.mode != MODE_SLEEP0);
      s_nxt.halted = !mode_running(s_nxt.mode);
   end

   // single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.mode <= MODE_NORMAL;
         s_r.high_low_clock_select <= HIGH_LOW_CLOCK_SELECT_RST;
         s_r.low_clock_selector <= LCKS_RST;
         s_r.idle_enable <= IDLE_EN_RST;
         s_r.system_clock_keep_on <= KEEP_ON_RST;
         s_r.act_fast <= HIGH_LOW_CLOCK_SELECT_RST;
         s_r.act_sel <= LCKS_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state register
   always_comb begin
      prdata = s_r.prdata;
      pready = s_r.pready;
      pslverr = s_r.pslverr;
      cpu_clk_en = s_r.cpu_clk_en;
      sys_clk_en = s_r.sys_clk_en;
      substitute_clock_en = s_r.sub_en;
      slow_peripheral_clock_en = s_r.slow_per_en;
      accumulator_clock_en = s_r.acc_en;
      fast_osc_on = s_r.fast_on;
      fast_div16_en = s_r.div16_en;
      fast_div64_en = s_r.div64_en;
      wdt_function_en = s_r.wdt_en;
      cpu_halted = s_r.halted;
   end

endmodule

// [sim/smc_checker.sv]
`timescale 1ns/1ps
module smc_checker
   import smc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic slow_rc_tick,
   input wire logic wdt_enable,
   input wire logic cpu_clk_en,
   input wire logic substitute_clock_en,
   input wire logic accumulator_clock_en,
   input wire logic fast_osc_on,
   input wire logic fast_div16_en,
   input wire logic fast_div64_en,
   input wire logic wdt_function_en,
   input wire logic cpu_halted
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // bus answer and register read-back
   a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single access-cycle pulse");
   a_unused_zero: assert property (
      pready && !pwrite && paddr == CMC_OFFSET |-> !prdata[CMC_UNUSED_BIT])
      else $error("unused bit read as one");
   // halt and wake of the cpu
   a_halt_enter: assert property (halt_req && !cpu_halted |-> ##[1:2] cpu_halted)
      else $error("halt not taken");
   a_wake_leave: assert property (wake_req && cpu_halted |-> ##[1:2] !cpu_halted)
      else $error("wake not taken");
   a_cpu_stops: assert property (cpu_halted |-> !cpu_clk_en)
      else $error("cpu clock while halted");
   // peripheral clocks and watchdog gating
   a_wdt_gate: assert property (wdt_function_en |-> $past(wdt_enable))
      else $error("watchdog function without enable");
   a_sub_source: assert property (substitute_clock_en |-> $past(slow_rc_tick))
      else $error("substitute clock without rc tick");
   a_sub_run: assert property ($past(presetn) && !cpu_halted && !$past(cpu_halted)
      && $past(slow_rc_tick) |-> substitute_clock_en)
      else $error("substitute clock missing while running");
   a_acc_halted: assert property (accumulator_clock_en |-> cpu_halted || $past(cpu_halted))
      else $error("accumulator clock while running");
   a_fast_off_div: assert property (!fast_osc_on && !$past(fast_osc_on)
      |-> !fast_div16_en && !fast_div64_en)
      else $error("fast divider pulse with oscillator off");

   c_halt: cover property (halt_req && !cpu_halted);
   c_wake: cover property (wake_req && cpu_halted);
   c_acc: cover property (accumulator_clock_en);
endmodule

// [sim/tb_smc_top.sv]
`timescale 1ns/1ps
module tb_smc_top;
   import smc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, halt_req, wake_req, slow_rc_tick;
   logic wdt_enable, low_voltage_detect_enable, pready, pslverr, cpu_clk_en, sys_clk_en;
   logic substitute_clock_en, slow_peripheral_clock_en, accumulator_clock_en, fast_osc_on;
   logic fast_div16_en, fast_div64_en, wdt_function_en, cpu_halted, e;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, r, w;
   logic [3:0] cfg [5];
   logic [2:0] m;
   int n_errors, n_tests, cyc, na, ns, ny, np, n;

   smc_top smc_top_inst (.*);

   // free running clock
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end

   // slow rc ticks at random and the hang limit
   always @(posedge pclk) begin
      slow_rc_tick <= ($urandom % 4) == 0;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end

   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         n_errors++;
         $display("mismatch %s exp %h got %h", s, x, g);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      chk("pready", 1, pready);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // cycles between two cpu clock pulses
   task automatic period(output int p);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (cpu_clk_en !== 1'b1 && k < 200);
      p = 0;
      do begin
         @(posedge pclk);
         p++;
      end while (cpu_clk_en !== 1'b1 && p < 200);
   endtask

   // halt mode from idle, keep-on, watchdog, low voltage bits
   function automatic logic [2:0] em(input logic [3:0] c);
      if (c[3]) return c[2] ? MODE_IDLE1 : MODE_IDLE0;
      return (c[1] | c[0]) ? MODE_SLEEP1 : MODE_SLEEP0;
   endfunction

   task conclude;
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      void'($urandom(32'hb029_ddb5));
      {psel, penable, pwrite, halt_req, wake_req} = '0;
      {wdt_enable, low_voltage_detect_enable} = '0;
      paddr = '0;
      pwdata = '0;
      presetn = 0;
      cfg = '{4'h8, 4'hc, 4'h2, 4'h1, 4'h0};
      repeat (12) @(posedge pclk);
      presetn <= 1;
      apb(0, CMC_OFFSET, 0);
      chk("cmc reset", 32'h0000_0003, r & 32'hffff_fff7);
      repeat (30) @(posedge pclk);
      apb(0, CMC_OFFSET, 0);
      chk("cmc ready", 32'h0000_000f, r);
      for (int t = 0; t < 8; t++) begin
         w = {24'h0, 8'($urandom)} | 32'h0000_0001;
         apb(1, CMC_OFFSET, w);
         apb(0, CMC_OFFSET, 0);
         chk("cmc rw", (w & 32'h0000_00e3) | 32'h0000_000c, r);
         apb(1, CMC2_OFFSET, w);
         apb(0, CMC2_OFFSET, 0);
         chk("cmc2 rw", w & 32'h0000_0001, r);
      end
      apb(0, 12'h00c, 0);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, r);
      for (int c = 0; c < 5; c++) begin
         m = em(cfg[c]);
         apb(1, CMC_OFFSET, {30'h0, cfg[c][3], 1'b1});
         apb(1, CMC2_OFFSET, {31'h0, cfg[c][2]});
         wdt_enable <= cfg[c][1];
         low_voltage_detect_enable <= cfg[c][0];
         @(posedge pclk);
         halt_req <= 1;
         @(posedge pclk);
         halt_req <= 0;
         repeat (4) @(posedge pclk);
         chk("halted", 1, cpu_halted);
         apb(0, STAT_OFFSET, 0);
         chk("mode", {27'h0, m == MODE_IDLE1, 1'b0, m}, r);
         apb(0, CMC_OFFSET, 0);
         chk("flags", {28'h0, m != MODE_SLEEP0, m == MODE_IDLE1, cfg[c][3], 1'b1}, r);
         {na, ns, ny, np} = '0;
         repeat (40) begin
            @(posedge pclk);
            na += accumulator_clock_en;
            ns += substitute_clock_en;
            ny += sys_clk_en;
            np += slow_peripheral_clock_en;
         end
         chk("slow per clk", m != MODE_SLEEP0, np != 0);
         chk("acc clk", m != MODE_SLEEP0, na != 0);
         chk("sub clk", m != MODE_SLEEP0, ns != 0);
         chk("sys clk", m == MODE_IDLE1, ny != 0);
         chk("wdt fn", cfg[c][1], wdt_function_en);
         @(posedge pclk);
         wake_req <= 1;
         @(posedge pclk);
         wake_req <= 0;
         repeat (25) @(posedge pclk);
         apb(0, STAT_OFFSET, 0);
         chk("normal", 32'h0000_0018, r);
      end
      {na, ns} = '0;
      repeat (64) begin
         @(posedge pclk);
         na += fast_div16_en;
         ns += fast_div64_en;
      end
      chk("div16 count", 4, na);
      chk("div64 count", 1, ns);
      for (int s = 2; s < 8; s++) begin
         apb(1, CMC_OFFSET, {24'h0, 3'(s), 5'h02});
         repeat (140) @(posedge pclk);
         period(n);
         chk("period", 1 << (8 - s), n);
      end
      apb(0, STAT_OFFSET, 0);
      chk("slow mode", 32'h0000_0019, r);
      apb(1, CMC_OFFSET, 32'h0000_0002);
      repeat (20) @(posedge pclk);
      chk("fast off", 0, fast_osc_on);
      apb(1, CMC_OFFSET, 32'h0000_0003);
      repeat (40) @(posedge pclk);
      period(n);
      chk("fast period", 1, n);
      chk("fast on", 1, fast_osc_on);
      conclude();
   end
endmodule

bind smc_top smc_checker smc_checker_inst (.*);
